// ===== verilog/tmr8_defs.svh
// Register offsets, field positions, reset values and counts of the timer
`ifndef TMR8_DEFS_SVH
`define TMR8_DEFS_SVH

`define OFS_COUNT_VALUE        6'h00
`define OFS_COMPARE_A_VALUE    6'h01
`define OFS_COMPARE_B_VALUE    6'h02
`define OFS_TIMER_CONTROL      6'h03
`define OFS_TIMER_CTRL_STATUS  6'h04
`define OFS_TIMER_CLOCK_CTRL   6'h05

`define BIT_MATCH_B_FLAG       7
`define BIT_MATCH_A_FLAG       6
`define BIT_WRAP_FLAG          5
`define BIT_STATUS_RSV         4
`define BIT_OUT_SEL_B_HI       3
`define BIT_OUT_SEL_B_LO       2
`define BIT_OUT_SEL_A_HI       1
`define BIT_OUT_SEL_A_LO       0

`define BIT_IRQ_EN_B           7
`define BIT_IRQ_EN_A           6
`define BIT_IRQ_EN_WRAP        5
`define BIT_CLEAR_SEL_HI       4
`define BIT_CLEAR_SEL_LO       3
`define BIT_CLK_SEL_HI         2
`define BIT_CLK_SEL_LO         0
`define BIT_EXT_CLEAR_LEVEL    0

`define RST_COUNT_VALUE        8'h00
`define RST_COMPARE_VALUE      8'hff
`define RST_TIMER_CONTROL      8'h00
`define RST_STATUS_CH1         8'h10
`define RST_CLOCK_CTRL         8'h00
`define COUNT_MAX              8'hff

`define CLR_NONE               2'b00
`define CLR_MATCH_A            2'b01
`define CLR_MATCH_B            2'b10
`define CLR_EXTERNAL           2'b11

`define DIV_FAST               8
`define DIV_MID                64
`define DIV_SLOW               8192

`endif

// ===== verilog/tmr8_pkg.sv
// Types shared by the timer files
package tmr8_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    OUT_KEEP   = 2'b00,
    OUT_LOW    = 2'b01,
    OUT_HIGH   = 2'b10,
    OUT_TOGGLE = 2'b11
  } out_act_t;

  typedef enum logic [2:0] {
    CLK_STOP     = 3'b000,
    CLK_DIV_FAST = 3'b001,
    CLK_DIV_MID  = 3'b010,
    CLK_DIV_SLOW = 3'b011,
    CLK_RSV      = 3'b100,
    CLK_EXT_RISE = 3'b101,
    CLK_EXT_FALL = 3'b110,
    CLK_EXT_BOTH = 3'b111
  } clk_sel_t;

endpackage : tmr8_pkg

// ===== verilog/count_tick_gen.sv
// Count clock source: internal prescaler taps or external clock edges
`include "tmr8_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module count_tick_gen
  import tmr8_pkg::*;
#(
  parameter int SLOW_DIV = `DIV_SLOW
) (
  input  wire logic     i_sys_clk,
  input  wire logic     i_reset_n,
  input  wire clk_sel_t i_clk_sel,
  input  wire logic     i_ext_clk,
  output logic          o_tick
);

  logic [5:0]  presc_ff;
  logic [12:0] slow_ff;
  logic        ext_prev_ff;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      presc_ff <= 6'h00;
    end else begin
      presc_ff <= presc_ff + 6'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slow_ff <= 13'h0000;
    end else if (slow_ff == 13'(SLOW_DIV - 1)) begin
      slow_ff <= 13'h0000;
    end else begin
      slow_ff <= slow_ff + 13'h0001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= i_ext_clk;
    end
  end

  always_comb begin
    case (i_clk_sel)
      CLK_DIV_FAST: o_tick = (presc_ff[2:0] == 3'(`DIV_FAST - 1));
      CLK_DIV_MID:  o_tick = (presc_ff == 6'(`DIV_MID - 1));
      CLK_DIV_SLOW: o_tick = (slow_ff == 13'(SLOW_DIV - 1));
      CLK_EXT_RISE: o_tick = i_ext_clk & ~ext_prev_ff;
      CLK_EXT_FALL: o_tick = ~i_ext_clk & ext_prev_ff;
      CLK_EXT_BOTH: o_tick = i_ext_clk ^ ext_prev_ff;
      default:      o_tick = 1'b0;
    endcase
  end

endmodule : count_tick_gen
`default_nettype wire

// ===== verilog/match_unit.sv
// One compare channel: match detection and its output action
`timescale 1ns/1ps
`default_nettype none
module match_unit
  import tmr8_pkg::*;
(
  input  wire byte_t      i_count,
  input  wire byte_t      i_compare,
  input  wire logic       i_tick,
  input  wire logic       i_compare_wr,
  input  wire logic [1:0] i_out_sel,
  output logic            o_match,
  output out_act_t        o_act
);

  // Match fires on the count tick while equal; a compare write inhibits it
  assign o_match = i_tick & (i_count == i_compare) & ~i_compare_wr;
  assign o_act   = o_match ? out_act_t'(i_out_sel) : OUT_KEEP;

endmodule : match_unit
`default_nettype wire

// ===== verilog/dual_compare_eight_bit_timer.sv
// 8-bit timer channel with two compares, wrap flag, pin output and APB slave
`include "tmr8_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_compare_eight_bit_timer
  import tmr8_pkg::*;
#(
  parameter int SLOW_DIV = `DIV_SLOW
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_paddr,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_ext_clk,
  input  wire logic        i_ext_clear_in,
  input  wire logic        i_transfer_ack_a,
  input  wire logic        i_transfer_ack_b,
  input  wire logic        i_transfer_irq_disable_sel,
  output logic             o_timer_out_pin,
  output logic             o_timer_out_oe_n,
  output logic             o_match_a_irq,
  output logic             o_match_b_irq,
  output logic             o_wrap_irq
);

  byte_t       count_value_ff;
  byte_t       compare_a_value_ff;
  byte_t       compare_b_value_ff;
  byte_t       timer_control_ff;
  logic        ext_clear_level_sel_ff;
  logic        match_a_flag_ff;
  logic        match_b_flag_ff;
  logic        wrap_flag_ff;
  logic        arm_a_ff;
  logic        arm_b_ff;
  logic        arm_wrap_ff;
  logic [3:0]  out_sel_ff;
  logic        timer_out_ff;
  logic        oe_n_ff;
  logic        ext_clr_prev_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        irq_a_ff;
  logic        irq_b_ff;
  logic        irq_wrap_ff;

  logic        tick;
  logic        match_a;
  logic        match_b;
  out_act_t    act_a;
  out_act_t    act_b;
  logic        ext_clr;
  logic        clr_evt;
  logic        wrap_evt;
  logic [1:0]  clear_sel;
  logic [5:0]  reg_idx;
  logic        addr_ok;
  logic        apb_done;
  logic        wr_en;
  logic        rd_en;
  logic        wr_count;
  logic        wr_cmp_a;
  logic        wr_cmp_b;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_clk_ctrl;
  logic        rd_status;
  byte_t       wbyte;
  byte_t       status_rd;
  byte_t       nxt_count;
  logic        nxt_timer_out;
  logic [31:0] nxt_prdata;

  // APB decode: one wait state, effects at the completing edge
  assign reg_idx     = i_paddr[7:2];
  assign addr_ok     = (reg_idx <= `OFS_TIMER_CLOCK_CTRL)
                       && (i_paddr[1:0] == 2'b00);
  assign apb_done    = i_psel & i_penable & pready_ff;
  assign wr_en       = apb_done & i_pwrite & addr_ok;
  assign rd_en       = apb_done & ~i_pwrite & addr_ok;
  assign wbyte       = i_pwdata[7:0];
  assign wr_count    = wr_en & (reg_idx == `OFS_COUNT_VALUE);
  assign wr_cmp_a    = wr_en & (reg_idx == `OFS_COMPARE_A_VALUE);
  assign wr_cmp_b    = wr_en & (reg_idx == `OFS_COMPARE_B_VALUE);
  assign wr_ctrl     = wr_en & (reg_idx == `OFS_TIMER_CONTROL);
  assign wr_status   = wr_en & (reg_idx == `OFS_TIMER_CTRL_STATUS);
  assign wr_clk_ctrl = wr_en & (reg_idx == `OFS_TIMER_CLOCK_CTRL);
  assign rd_status   = rd_en & (reg_idx == `OFS_TIMER_CTRL_STATUS);

  assign status_rd = {match_b_flag_ff, match_a_flag_ff, wrap_flag_ff,
                      1'b1, out_sel_ff};

  count_tick_gen #(
    .SLOW_DIV (SLOW_DIV)
  ) u_tick (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_clk_sel (clk_sel_t'(timer_control_ff[`BIT_CLK_SEL_HI:
                                             `BIT_CLK_SEL_LO])),
    .i_ext_clk (i_ext_clk),
    .o_tick    (tick)
  );

  match_unit u_match_a (
    .i_count      (count_value_ff),
    .i_compare    (compare_a_value_ff),
    .i_tick       (tick),
    .i_compare_wr (wr_cmp_a),
    .i_out_sel    (out_sel_ff[`BIT_OUT_SEL_A_HI:`BIT_OUT_SEL_A_LO]),
    .o_match      (match_a),
    .o_act        (act_a)
  );

  match_unit u_match_b (
    .i_count      (count_value_ff),
    .i_compare    (compare_b_value_ff),
    .i_tick       (tick),
    .i_compare_wr (wr_cmp_b),
    .i_out_sel    (out_sel_ff[`BIT_OUT_SEL_B_HI:`BIT_OUT_SEL_B_LO]),
    .o_match      (match_b),
    .o_act        (act_b)
  );

  // Counter clear sources
  assign clear_sel = timer_control_ff[`BIT_CLEAR_SEL_HI:`BIT_CLEAR_SEL_LO];
  assign ext_clr   = ext_clear_level_sel_ff ? i_ext_clear_in
                     : (i_ext_clear_in & ~ext_clr_prev_ff);

  always_comb begin
    case (clear_sel)
      `CLR_MATCH_A:  clr_evt = match_a;
      `CLR_MATCH_B:  clr_evt = match_b;
      `CLR_EXTERNAL: clr_evt = ext_clr;
      default:       clr_evt = 1'b0;
    endcase
  end

  assign wrap_evt = tick & (count_value_ff == `COUNT_MAX)
                    & ~clr_evt & ~wr_count;

  // Counter: clear, then write, then increment
  always_comb begin
    if (clr_evt) begin
      nxt_count = 8'h00;
    end else if (wr_count) begin
      nxt_count = wbyte;
    end else if (tick) begin
      nxt_count = count_value_ff + 8'h01;
    end else begin
      nxt_count = count_value_ff;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_value_ff <= `RST_COUNT_VALUE;
    end else begin
      count_value_ff <= nxt_count;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_clr_prev_ff <= 1'b0;
    end else begin
      ext_clr_prev_ff <= i_ext_clear_in;
    end
  end

  // Software registers
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      compare_a_value_ff     <= `RST_COMPARE_VALUE;
      compare_b_value_ff     <= `RST_COMPARE_VALUE;
      timer_control_ff       <= `RST_TIMER_CONTROL;
      ext_clear_level_sel_ff <= 1'b0;
      out_sel_ff             <= 4'h0;
    end else begin
      if (wr_cmp_a) begin
        compare_a_value_ff <= wbyte;
      end
      if (wr_cmp_b) begin
        compare_b_value_ff <= wbyte;
      end
      if (wr_ctrl) begin
        timer_control_ff <= wbyte;
      end
      if (wr_clk_ctrl) begin
        ext_clear_level_sel_ff <= wbyte[`BIT_EXT_CLEAR_LEVEL];
      end
      if (wr_status) begin
        out_sel_ff <= wbyte[3:0];
      end
    end
  end

  // Flags: set wins over any clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      match_a_flag_ff <= 1'b0;
    end else if (match_a) begin
      match_a_flag_ff <= 1'b1;
    end else if (wr_status && arm_a_ff && !wbyte[`BIT_MATCH_A_FLAG]) begin
      match_a_flag_ff <= 1'b0;
    end else if (i_transfer_ack_a && !i_transfer_irq_disable_sel) begin
      match_a_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      match_b_flag_ff <= 1'b0;
    end else if (match_b) begin
      match_b_flag_ff <= 1'b1;
    end else if (wr_status && arm_b_ff && !wbyte[`BIT_MATCH_B_FLAG]) begin
      match_b_flag_ff <= 1'b0;
    end else if (i_transfer_ack_b && !i_transfer_irq_disable_sel) begin
      match_b_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wrap_flag_ff <= 1'b0;
    end else if (wrap_evt) begin
      wrap_flag_ff <= 1'b1;
    end else if (wr_status && arm_wrap_ff && !wbyte[`BIT_WRAP_FLAG]) begin
      wrap_flag_ff <= 1'b0;
    end
  end

  // Read-as-1 arms the clear; any status write disarms
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arm_a_ff    <= 1'b0;
      arm_b_ff    <= 1'b0;
      arm_wrap_ff <= 1'b0;
    end else if (wr_status) begin
      arm_a_ff    <= 1'b0;
      arm_b_ff    <= 1'b0;
      arm_wrap_ff <= 1'b0;
    end else if (rd_status) begin
      arm_a_ff    <= prdata_ff[`BIT_MATCH_A_FLAG];
      arm_b_ff    <= prdata_ff[`BIT_MATCH_B_FLAG];
      arm_wrap_ff <= prdata_ff[`BIT_WRAP_FLAG];
    end
  end

  // Pin output with priority toggle, 1, 0, keep
  always_comb begin
    if (act_a == OUT_TOGGLE || act_b == OUT_TOGGLE) begin
      nxt_timer_out = ~timer_out_ff;
    end else if (act_a == OUT_HIGH || act_b == OUT_HIGH) begin
      nxt_timer_out = 1'b1;
    end else if (act_a == OUT_LOW || act_b == OUT_LOW) begin
      nxt_timer_out = 1'b0;
    end else begin
      nxt_timer_out = timer_out_ff;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_out_ff <= 1'b0;
    end else begin
      timer_out_ff <= nxt_timer_out;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= (out_sel_ff == 4'h0);
    end
  end

  // Interrupt request levels
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_a_ff    <= 1'b0;
      irq_b_ff    <= 1'b0;
      irq_wrap_ff <= 1'b0;
    end else begin
      irq_a_ff    <= match_a_flag_ff & timer_control_ff[`BIT_IRQ_EN_A];
      irq_b_ff    <= match_b_flag_ff & timer_control_ff[`BIT_IRQ_EN_B];
      irq_wrap_ff <= wrap_flag_ff & timer_control_ff[`BIT_IRQ_EN_WRAP];
    end
  end

  // APB read data captured in the setup cycle
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (reg_idx)
      `OFS_COUNT_VALUE:       nxt_prdata[7:0] = count_value_ff;
      `OFS_COMPARE_A_VALUE:   nxt_prdata[7:0] = compare_a_value_ff;
      `OFS_COMPARE_B_VALUE:   nxt_prdata[7:0] = compare_b_value_ff;
      `OFS_TIMER_CONTROL:     nxt_prdata[7:0] = timer_control_ff;
      `OFS_TIMER_CTRL_STATUS: nxt_prdata[7:0] = status_rd;
      `OFS_TIMER_CLOCK_CTRL:  nxt_prdata[0] = ext_clear_level_sel_ff;
      default:                nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      if (i_psel && !i_penable) begin
        prdata_ff <= addr_ok ? nxt_prdata : 32'h0000_0000;
      end
      // Error rises with pready so the output comes straight from a register
      pslverr_ff <= i_psel & i_penable & ~pready_ff & ~addr_ok;
      pready_ff  <= i_psel & i_penable & ~pready_ff;
    end
  end

  assign o_prdata         = prdata_ff;
  assign o_pready         = pready_ff;
  assign o_pslverr        = pslverr_ff;
  assign o_timer_out_pin  = timer_out_ff;
  assign o_timer_out_oe_n = oe_n_ff;
  assign o_match_a_irq    = irq_a_ff;
  assign o_match_b_irq    = irq_b_ff;
  assign o_wrap_irq       = irq_wrap_ff;

  // Helper: any compare match seen since reset
  logic seen_match_ff;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seen_match_ff <= 1'b0;
    end else if (match_a || match_b) begin
      seen_match_ff <= 1'b1;
    end
  end

  property p_flag_b_set;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      match_b |=> match_b_flag_ff;
  endproperty
  a_flag_b_set: assert property (p_flag_b_set)
    else $error("Compare-B flag not set after match");

  property p_flag_a_set;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      match_a |=> match_a_flag_ff;
  endproperty
  a_flag_a_set: assert property (p_flag_a_set)
    else $error("Compare-A flag not set after match");

  property p_wrap_set;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      tick && count_value_ff == 8'hff && !clr_evt && !wr_count
      |=> wrap_flag_ff && count_value_ff == 8'h00;
  endproperty
  a_wrap_set: assert property (p_wrap_set)
    else $error("Wrap did not set flag or reach zero");

  property p_clear_needs_arm;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      $fell(wrap_flag_ff) |-> $past(arm_wrap_ff) && $past(wr_status);
  endproperty
  a_clear_needs_arm: assert property (p_clear_needs_arm)
    else $error("Wrap flag cleared without prior read");

  property p_transfer_clear;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_transfer_ack_a && !i_transfer_irq_disable_sel && !match_a
      |=> !match_a_flag_ff;
  endproperty
  a_transfer_clear: assert property (p_transfer_clear)
    else $error("Transfer ack did not clear compare-A flag");

  property p_rsv_bit;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      rd_status |-> o_prdata[`BIT_STATUS_RSV];
  endproperty
  a_rsv_bit: assert property (p_rsv_bit)
    else $error("Reserved status bit read as 0");

  property p_toggle_a;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      match_a && act_a == OUT_TOGGLE
      |=> o_timer_out_pin != $past(o_timer_out_pin);
  endproperty
  a_toggle_a: assert property (p_toggle_a)
    else $error("Pin did not toggle on compare-A match");

  property p_out_disable;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      out_sel_ff == 4'h0 |=> o_timer_out_oe_n;
  endproperty
  a_out_disable: assert property (p_out_disable)
    else $error("Pin enabled with output select zero");

  property p_out_low_first;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !seen_match_ff |-> !o_timer_out_pin;
  endproperty
  a_out_low_first: assert property (p_out_low_first)
    else $error("Pin high before first match");

  property p_clear_a;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      clear_sel == `CLR_MATCH_A && match_a |=> count_value_ff == 8'h00;
  endproperty
  a_clear_a: assert property (p_clear_a)
    else $error("Counter not cleared on compare-A match");

  property p_clear_beats_write;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      clr_evt && wr_count |=> count_value_ff == 8'h00;
  endproperty
  a_clear_beats_write: assert property (p_clear_beats_write)
    else $error("Counter write beat a clear");

  c_pulse_mode: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    clear_sel == `CLR_MATCH_A && out_sel_ff == 4'h6 && match_b);
  c_wrap: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    wrap_evt);
  c_both_match: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    match_a && match_b);
  c_ext_clear: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    clear_sel == `CLR_EXTERNAL && ext_clr);

endmodule : dual_compare_eight_bit_timer
`default_nettype wire

// ===== testbench/ext_pins_model.sv
// External pin model: count clock, clear input and transfer controller
`timescale 1ns/1ps
`default_nettype none
module ext_pins_model (
  input  wire logic i_sys_clk,
  output logic      o_ext_clk,
  output logic      o_ext_clear,
  output logic      o_ack_a,
  output logic      o_ack_b,
  output logic      o_disable_sel
);
  initial begin
    o_ext_clk = 1'b0;
    o_ext_clear = 1'b0;
    o_ack_a = 1'b0;
    o_ack_b = 1'b0;
    o_disable_sel = 1'b1;
  end
  // Count clock pulses two clocks high, three or more low
  task automatic clk_pulses(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_ext_clk <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      o_ext_clk <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
    end
    repeat (2) @(posedge i_sys_clk);
  endtask : clk_pulses
  task automatic clear_pulse();
    @(posedge i_sys_clk);
    o_ext_clear <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    o_ext_clear <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask : clear_pulse
  // One-cycle service acknowledge for channel A or B
  task automatic ack(input logic is_a, input logic dis);
    @(posedge i_sys_clk);
    o_disable_sel <= dis;
    o_ack_a <= is_a;
    o_ack_b <= !is_a;
    @(posedge i_sys_clk);
    o_ack_a <= 1'b0;
    o_ack_b <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
  endtask : ack
endmodule : ext_pins_model
`default_nettype wire

// ===== testbench/testbench.sv
// Register-level testbench of the timer channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tmr8_pkg::*;
  logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        ext_clk, ext_clr, ack_a, ack_b, dis_sel;
  logic        pin, oe_n, irq_a, irq_b, irq_w, err;
  byte_t       rdata;
  int          n_fail, cmp_count;

  dual_compare_eight_bit_timer #(.SLOW_DIV(16)) DUT (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_paddr(paddr),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_ext_clk(ext_clk), .i_ext_clear_in(ext_clr),
    .i_transfer_ack_a(ack_a), .i_transfer_ack_b(ack_b),
    .i_transfer_irq_disable_sel(dis_sel), .o_timer_out_pin(pin),
    .o_timer_out_oe_n(oe_n), .o_match_a_irq(irq_a),
    .o_match_b_irq(irq_b), .o_wrap_irq(irq_w));
  ext_pins_model PINS (.i_sys_clk(sys_clk), .o_ext_clk(ext_clk),
    .o_ext_clear(ext_clr), .o_ack_a(ack_a), .o_ack_b(ack_b),
    .o_disable_sel(dis_sel));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input byte_t exp, input byte_t got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bounded count
  task automatic apb(input logic w, input logic [7:0] a, input byte_t d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 8'h01, 8'h00);
    rdata = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input byte_t d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input byte_t exp, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, exp, rdata);
  endtask : rd

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    n_fail = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk("oe_n", 8'h01, {7'h0, oe_n});
    rd(8'h00, 8'h00, "count");
    rd(8'h04, 8'hff, "cmp_a");
    rd(8'h08, 8'hff, "cmp_b");
    rd(8'h0c, 8'h00, "ctrl");
    rd(8'h10, 8'h10, "status");
    rd(8'h14, 8'h00, "clkctrl");
    rd(8'h18, 8'h00, "unmapped");
    chk("slverr", 8'h01, {7'h0, err});
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h1f, "status");
    $display("test reset done");
    wr(8'h10, 8'h06);
    wr(8'h04, 8'h04);
    wr(8'h08, 8'h01);
    wr(8'h0c, 8'h4d);
    PINS.clk_pulses(2);
    rd(8'h00, 8'h02, "count");
    chk("pin", 8'h00, {7'h0, pin});
    chk("oe_n", 8'h00, {7'h0, oe_n});
    PINS.clk_pulses(3);
    rd(8'h00, 8'h00, "count");
    chk("pin", 8'h01, {7'h0, pin});
    chk("irq_a", 8'h01, {7'h0, irq_a});
    wr(8'h10, 8'h16);
    rd(8'h10, 8'hd6, "status");
    wr(8'h10, 8'h16);
    rd(8'h10, 8'h16, "status");
    chk("irq_a", 8'h00, {7'h0, irq_a});
    PINS.clk_pulses(2);
    chk("pin", 8'h00, {7'h0, pin});
    $display("test pulse done");
    PINS.clk_pulses(3);
    PINS.ack(1'b1, 1'b1);
    rd(8'h10, 8'hd6, "status");
    PINS.ack(1'b1, 1'b0);
    rd(8'h10, 8'h96, "status");
    $display("test ack done");
    wr(8'h0c, 8'h05);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h02);
    wr(8'h08, 8'h02);
    wr(8'h10, 8'h0e);
    chk("pin", 8'h01, {7'h0, pin});
    PINS.clk_pulses(3);
    chk("pin", 8'h00, {7'h0, pin});
    rd(8'h00, 8'h03, "count");
    wr(8'h00, 8'hfe);
    PINS.clk_pulses(2);
    rd(8'h00, 8'h00, "count");
    rd(8'h10, 8'hfe, "status");
    wr(8'h0c, 8'he5);
    rd(8'h10, 8'hfe, "status");
    chk("irq_b", 8'h01, {7'h0, irq_b});
    chk("irq_w", 8'h01, {7'h0, irq_w});
    PINS.ack(1'b0, 1'b0);
    rd(8'h10, 8'h7e, "status");
    $display("test toggle and wrap done");
    wr(8'h14, 8'h01);
    wr(8'h0c, 8'h1d);
    wr(8'h00, 8'h50);
    PINS.clear_pulse();
    rd(8'h00, 8'h00, "count");
    $display("test external clear done");
    // Internal divide by 8: 64 clocks between the two control writes
    wr(8'h0c, 8'h01);
    repeat (60) @(posedge sys_clk);
    wr(8'h0c, 8'h00);
    rd(8'h00, 8'h08, "count");
    chk("slverr", 8'h00, {7'h0, err});
    $display("test prescaler done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
